// ### eeprom_device.sv
// Purpose: serial slave giving access to a 256 x 8 memory
// Assumes: master drives the clock; lines filtered before use
// Notes: memory contents are not reset; they model storage
`default_nettype none

module eeprom_device
  import eeprom_link_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC,
  parameter logic [6:0] SLAVE_ADDR = MEM_SLAVE_ADDR
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Link
  eeprom_link_if.device link,
  // Status
  output logic busy_out
);
  localparam int TW = $clog2(WR_CYCLES + 1);

  typedef struct packed {
    dev_st_t st;
    logic scl_p;
    logic sda_p;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic ack_arm;
    logic in_ack;
    logic ld;
    logic [7:0] addr;
    logic pend;
    logic busy;
    logic [TW-1:0] tmr;
    logic [PAGE_BYTES-1:0] vld;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic sda_oe_n;
  } dev_t;

  dev_t q;
  dev_t d;
  logic scl_f;
  logic sda_f;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic [PAGE_BITS-1:0] slot;
  logic [PAGE_BITS-1:0] prog_slot;

  logic [7:0] mem [MEM_WORDS];

  line_filter u_scl_flt (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .line_in(link.scl),
    .line_out(scl_f)
  );

  line_filter u_sda_flt (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .line_in(link.sda),
    .line_out(sda_f)
  );

  assign rd_byte = mem[q.addr];
  assign slot = q.addr[PAGE_BITS-1:0];
  assign prog_slot = q.tmr[PAGE_BITS-1:0];

  always_comb begin
    d = q;
    byte_in = {q.sh[6:0], sda_f};
    rise = scl_f & ~q.scl_p;
    fall = ~scl_f & q.scl_p;
    start_ev = scl_f & q.scl_p & q.sda_p & ~sda_f;
    stop_ev = scl_f & q.scl_p & ~q.sda_p & sda_f;
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    mem_we = 1'b0;
    mem_wa = {q.addr[7:PAGE_BITS], prog_slot};
    mem_wd = q.pbuf[prog_slot];

    if (q.busy) begin
      d.tmr = q.tmr + 1'b1;
      if (q.tmr < TW'(PAGE_BYTES)) begin
        mem_we = q.vld[prog_slot];
      end
      if (q.tmr == TW'(WR_CYCLES - 1)) begin
        d.busy = 1'b0;
      end
    end

    if (start_ev) begin
      d.st = D_ADDR;
      d.cnt = '0;
      d.ack_arm = 1'b0;
      d.in_ack = 1'b0;
      d.ld = 1'b0;
      d.pend = 1'b0;
      d.sda_oe_n = LINE_RELEASE;
    end else if (stop_ev) begin
      d.st = D_IDLE;
      d.ack_arm = 1'b0;
      d.in_ack = 1'b0;
      d.ld = 1'b0;
      d.sda_oe_n = LINE_RELEASE;
      if (q.pend && !q.busy) begin
        d.busy = 1'b1;
        d.tmr = '0;
        d.pend = 1'b0;
      end
    end else if (rise) begin
      unique case (q.st)
        D_ADDR, D_WORD, D_DATA: begin
          if (!q.in_ack) begin
            d.sh = byte_in;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == LAST_BIT) begin
              d.ack_arm = 1'b1;
              if (q.st == D_ADDR) begin
                if (byte_in[7:1] != SLAVE_ADDR || q.busy) begin
                  d.st = D_IGNORE;
                  d.ack_arm = 1'b0;
                end else if (byte_in[0] == DIR_WRITE) begin
                  d.st = D_WORD;
                  d.vld = '0;
                end else begin
                  d.st = D_TX;
                  d.ld = 1'b1;
                end
              end else if (q.st == D_WORD) begin
                d.addr = byte_in;
                d.st = D_DATA;
              end else begin
                d.pbuf[slot] = byte_in;
                d.vld[slot] = 1'b1;
                d.addr[PAGE_BITS-1:0] = slot + 1'b1;
                d.pend = 1'b1;
              end
            end
          end
        end
        D_TX: begin
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == LAST_BIT) begin
            d.st = D_RACK;
          end
        end
        D_RACK: begin
          if (sda_f == LINE_PULL) begin
            d.st = D_TX;
            d.in_ack = 1'b1;
            d.ld = 1'b1;
          end else begin
            d.st = D_IGNORE;
          end
        end
        D_IDLE, D_IGNORE: begin
        end
      endcase
    end else if (fall) begin
      if (q.ack_arm) begin
        d.ack_arm = 1'b0;
        d.in_ack = 1'b1;
        d.sda_oe_n = LINE_PULL;
      end else if (q.in_ack) begin
        d.in_ack = 1'b0;
        d.cnt = '0;
        d.sda_oe_n = LINE_RELEASE;
        if (q.ld) begin
          d.ld = 1'b0;
          d.sh = {rd_byte[6:0], 1'b0};
          d.sda_oe_n = rd_byte[7];
          d.addr = q.addr + 1'b1;
        end
      end else if (q.st == D_TX) begin
        d.sda_oe_n = q.sh[7];
        d.sh = {q.sh[6:0], 1'b0};
      end else if (q.st == D_RACK) begin
        d.sda_oe_n = LINE_RELEASE;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.scl_p <= LINE_RELEASE;
      q.sda_p <= LINE_RELEASE;
      q.sda_oe_n <= LINE_RELEASE;
    end else begin
      q <= d;
    end
  end

  // Storage keeps its contents over reset
  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link.dev_sda_out = LINE_PULL;
  assign link.dev_sda_oe_n = q.sda_oe_n;
  assign busy_out = q.busy;
endmodule : eeprom_device

`default_nettype wire

// ### eeprom_host.sv
// Purpose: bus master driving the two-wire link from simple commands
// Assumes: no clock stretching by the slave
// Notes: clock made by a quarter-period divider
`default_nettype none

module eeprom_host
  import eeprom_link_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Link
  eeprom_link_if.host link,
  // Commands
  input wire logic cmd_valid_in,
  input wire op_t cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  // Results
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic nack_out
);
  localparam int DW = $clog2(QTR + 1);

  typedef struct packed {
    host_st_t st;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [DW-1:0] div;
    logic last;
    logic [3:0] nclk;
    logic started;
    logic scl_oe_n;
    logic sda_oe_n;
    logic ready;
    logic done;
    logic [7:0] rdata;
    logic nack;
  } host_t;

  host_t q;
  host_t d;
  logic sda_f;
  logic tick;

  function automatic logic too_early(logic s, logic [3:0] n);
    return s && (n < 4'(MIN_START_CLKS));
  endfunction : too_early

  line_filter u_sda_flt (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .line_in(link.sda),
    .line_out(sda_f)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    tick = (q.div == DW'(QTR - 1));
    d.div = tick ? '0 : q.div + 1'b1;
    if (q.st == H_IDLE) begin
      if (cmd_valid_in && q.ready) begin
        d.ph = '0;
        d.bitn = '0;
        d.nack = 1'b0;
        d.ready = 1'b0;
        unique case (cmd_op_in)
          OP_WRITE: begin
            d.st = H_SEND;
            d.sh = cmd_data_in;
          end
          OP_READ_ACK, OP_READ_LAST: begin
            d.st = H_RECV;
            d.last = (cmd_op_in == OP_READ_LAST);
          end
          OP_START, OP_STOP: begin
            if (too_early(q.started, q.nclk)) begin
              d.ready = 1'b1;
              d.done = 1'b1;
              d.nack = 1'b1;
            end else begin
              d.st = (cmd_op_in == OP_START) ? H_START : H_STOP;
              d.sh = cmd_data_in;
            end
          end
          default: begin
            d.ready = 1'b1;
            d.done = 1'b1;
            d.nack = 1'b1;
          end
        endcase
      end
    end else if (tick) begin
      d.ph = q.ph + 1'b1;
      unique case (q.st)
        H_START: begin
          unique case (q.ph)
            2'h0: d.sda_oe_n = LINE_RELEASE;
            2'h1: d.scl_oe_n = LINE_RELEASE;
            2'h2: d.sda_oe_n = LINE_PULL;
            2'h3: begin
              d.scl_oe_n = LINE_PULL;
              d.started = 1'b1;
              d.nclk = '0;
              d.st = H_SEND;
            end
          endcase
        end
        H_SEND, H_RECV: begin
          unique case (q.ph)
            2'h0: begin
              if (q.st == H_SEND && q.bitn != ACK_SLOT) begin
                d.sda_oe_n = q.sh[7];
              end else if (q.st == H_RECV && q.bitn == ACK_SLOT) begin
                d.sda_oe_n = LINE_PULL;
              end else begin
                d.sda_oe_n = LINE_RELEASE;
              end
            end
            2'h1: d.scl_oe_n = LINE_RELEASE;
            2'h2: begin
              if (q.bitn != ACK_SLOT) begin
                d.sh = {q.sh[6:0], sda_f};
              end else if (q.st == H_SEND) begin
                d.nack = sda_f;
              end
            end
            2'h3: begin
              d.scl_oe_n = LINE_PULL;
              d.bitn = q.bitn + 1'b1;
              if (q.nclk != CNT_SAT) begin
                d.nclk = q.nclk + 1'b1;
              end
              // last read has no ack clock
              if (q.bitn == ACK_SLOT ||
                  (q.st == H_RECV && q.last && q.bitn == 4'(LAST_BIT))) begin
                d.st = H_IDLE;
                d.ready = 1'b1;
                d.done = 1'b1;
                d.rdata = q.sh;
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (q.ph)
            2'h0: d.sda_oe_n = LINE_PULL;
            2'h1: d.scl_oe_n = LINE_RELEASE;
            2'h2: d.sda_oe_n = LINE_RELEASE;
            2'h3: begin
              d.st = H_IDLE;
              d.started = 1'b0;
              d.ready = 1'b1;
              d.done = 1'b1;
            end
          endcase
        end
        H_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.scl_oe_n <= LINE_RELEASE;
      q.sda_oe_n <= LINE_RELEASE;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.host_scl_out = LINE_PULL;
  assign link.host_scl_oe_n = q.scl_oe_n;
  assign link.host_sda_out = LINE_PULL;
  assign link.host_sda_oe_n = q.sda_oe_n;
  assign cmd_ready_out = q.ready;
  assign done_out = q.done;
  assign rdata_out = q.rdata;
  assign nack_out = q.nack;
endmodule : eeprom_host

`default_nettype wire

// ### eeprom_link_checker.sv
// Purpose: timing checks on the two-wire link and the busy status
// Assumes: one core clock domain, synchronous active-low reset
// Notes: start and stop are seen on the raw wires, not the filtered ones
`default_nettype none

module eeprom_link_checker
  import eeprom_link_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n,
  // Status
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic scl_q;
  logic sda_q;
  logic bus_act_q;
  logic [3:0] rises_q;
  logic [7:0] since_stop_q;
  int busy_cnt_q;
  logic start_w;
  logic stop_w;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;

  // Saturating rise and stop counters keep the helpers cheap over long idle spans; the busy counter clears when not busy
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_act_q <= 1'b0;
      rises_q <= 4'h0;
      since_stop_q <= 8'hFF;
      busy_cnt_q <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      bus_act_q <= start_w ? 1'b1 : (stop_w ? 1'b0 : bus_act_q);
      if (start_w) begin
        rises_q <= 4'h0;
      end else if (scl && !scl_q && rises_q != 4'hF) begin
        rises_q <= rises_q + 4'h1;
      end
      if (stop_w) begin
        since_stop_q <= 8'h00;
      end else if (since_stop_q != 8'hFF) begin
        since_stop_q <= since_stop_q + 8'h01;
      end
      busy_cnt_q <= busy_out ? busy_cnt_q + 1 : 0;
    end
  end

  a_dev_quiet_idle: assert property (!bus_act_q |-> dev_sda_oe_n)
    else $error("device drives data while the bus is idle");
  a_nine_before_stop: assert property (
    (stop_w || (start_w && bus_act_q)) |-> rises_q >= 4'd9)
    else $error("stop or restart after fewer than nine clocks");
  a_busy_from_stop: assert property (
    $rose(busy_out) |-> since_stop_q < 8'd64)
    else $error("programming began without a recent stop");
  a_busy_min_run: assert property (
    $rose(busy_out) |=> busy_out [*8])
    else $error("programming cycle ended too soon");
  a_busy_bounded: assert property (
    busy_cnt_q <= WR_CYCLES + 1)
    else $error("programming cycle ran past its limit");
  a_busy_no_ack: assert property (busy_out |-> dev_sda_oe_n)
    else $error("device pulled data while programming");
  a_dev_change_low: assert property (
    $changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  a_scl_no_spike: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short to filter");
endmodule : eeprom_link_checker

`default_nettype wire

// ### eeprom_link_if.sv
// Purpose: two-wire link between the memory device and the bus master
// Assumes: pull-ups on both wires, modelled as wired-AND
// Notes: each driver gives a value and a low-active enable
`default_nettype none

interface eeprom_link_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport device (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport host (
    input sda,
    output host_scl_out,
    output host_scl_oe_n,
    output host_sda_out,
    output host_sda_oe_n
  );
endinterface : eeprom_link_if

`default_nettype wire

// ### eeprom_link_pkg.sv
// Purpose: shared constants and types for the serial memory link
// Assumes: both ends run on a 200 MHz core clock
// Notes: lines are open drain; a low enable pulls the wire low
`default_nettype none

package eeprom_link_pkg;

  localparam int CLK_NS = 5;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWR_MS = 10;
  localparam int WR_CYC = TWR_MS * 1000000 / CLK_NS;
  localparam int SCL_KHZ = 400;
  localparam int SCL_PER_NS = 1000000 / SCL_KHZ;
  localparam int QTR_CYC = (SCL_PER_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BITS = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MIN_START_CLKS = 9;
  // Arbitrary default slave address
  localparam logic [6:0] MEM_SLAVE_ADDR = 7'h50;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_SAT = 4'hF;
  localparam logic LINE_RELEASE = 1'b1;
  localparam logic LINE_PULL = 1'b0;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_WORD = 3'b010,
    D_DATA = 3'b011,
    D_TX = 3'b100,
    D_RACK = 3'b101,
    D_IGNORE = 3'b110
  } dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_SEND = 3'b010,
    H_RECV = 3'b011,
    H_STOP = 3'b100
  } host_st_t;

  typedef enum logic [2:0] {
    OP_START = 3'b000,
    OP_WRITE = 3'b001,
    OP_READ_ACK = 3'b010,
    OP_READ_LAST = 3'b011,
    OP_STOP = 3'b100
  } op_t;

endpackage : eeprom_link_pkg

`default_nettype wire

// ### i2c_eeprom_memory_access_tb_top.sv
// Purpose: host and device joined over the link, driven by commands
// Assumes: shortened programming time and a fast link divider
// Notes: expected results queue up; a monitor compares on each done
`default_nettype none

module i2c_eeprom_memory_access_tb_top
  import eeprom_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WR_T = 3000;
  localparam int QTR_T = 20;
  localparam logic [7:0] ADDR_W = {MEM_SLAVE_ADDR, DIR_WRITE};
  localparam logic [7:0] ADDR_R = {MEM_SLAVE_ADDR, DIR_READ};

  typedef struct packed {
    logic chk;
    logic rd;
    logic n;
    logic [7:0] d;
  } note_t;

  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  op_t cmd_op_in = OP_START;
  logic [7:0] cmd_data_in = 8'h00;
  logic cmd_ready_out;
  logic done_out;
  logic [7:0] rdata_out;
  logic nack_out;
  logic busy_out;
  logic last_nack;
  logic [7:0] mem_exp [256];
  note_t notes [$];
  note_t cur;
  int seed;
  int n_errors = 0;
  int comparisons = 0;

  eeprom_link_if link ();

  eeprom_device #(.WR_CYCLES(WR_T)) eeprom_device_inst (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .link(link),
    .busy_out(busy_out)
  );

  eeprom_host #(.QTR(QTR_T)) eeprom_host_inst (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .link(link),
    .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in),
    .cmd_data_in(cmd_data_in),
    .cmd_ready_out(cmd_ready_out),
    .done_out(done_out),
    .rdata_out(rdata_out),
    .nack_out(nack_out)
  );

  eeprom_link_checker #(.WR_CYCLES(WR_T)) eeprom_link_checker_inst (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .scl(link.scl),
    .sda(link.sda),
    .dev_sda_oe_n(link.dev_sda_oe_n),
    .busy_out(busy_out)
  );

  always #2.5 core_clk_in = ~core_clk_in;

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // One command, with its expected result noted before it is sent
  task automatic cmd(input op_t op, input logic [7:0] data,
                     input logic [7:0] d, input logic n, input logic chk);
    int k;
    note_t nt;
    nt.chk = chk;
    nt.rd = (op == OP_READ_ACK) || (op == OP_READ_LAST);
    nt.n = n;
    nt.d = d;
    k = 0;
    while (cmd_ready_out !== 1'b1 && k < 100) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    if (k >= 100) begin
      n_errors++;
      $display("MISMATCH ready expected 1 seen 0");
    end
    notes.push_back(nt);
    cmd_op_in = op;
    cmd_data_in = data;
    cmd_valid_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    cmd_valid_in = 1'b0;
    cmd_data_in = 8'($random(seed));
    k = 0;
    while (done_out !== 1'b1 && k < 2000) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    if (k >= 2000) begin
      n_errors++;
      $display("MISMATCH done expected 1 seen 0");
    end
    last_nack = nack_out;
    // Refused commands finish at once; let an edge pass before the next
    @(posedge core_clk_in);
    #1;
  endtask : cmd

  // Retry the address until programming ends; results vary, so unchecked
  task automatic poll_ack();
    int t;
    for (t = 0; t < 30; t++) begin
      cmd(OP_START, ADDR_W, 8'h00, 1'b0, 1'b0);
      if (last_nack === 1'b0) begin
        break;
      end
      cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    end
    if (t >= 30) begin
      n_errors++;
      $display("MISMATCH poll expected 0 seen 1");
    end
  endtask : poll_ack

  always @(negedge core_clk_in) begin
    if (done_out === 1'b1) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("MISMATCH note expected 1 seen 0");
      end else begin
        cur = notes.pop_front();
        chk_bit("ready", 1'b1, cmd_ready_out);
        if (cur.chk && cur.rd) begin
          chk_byte("rdata", cur.d, rdata_out);
        end else if (cur.chk) begin
          chk_bit("nack", cur.n, nack_out);
        end
      end
    end
  end

  initial begin
    #450000;
    n_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    int i;
    int k;
    logic [7:0] b;
    seed = 110;
    repeat (10) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    cmd(OP_START, ADDR_W, 8'h00, 1'b0, 1'b1);
    cmd(OP_WRITE, 8'h00, 8'h00, 1'b0, 1'b1);
    // seventeenth byte lands on slot 0
    for (i = 0; i < 17; i++) begin
      b = 8'($random(seed));
      mem_exp[i % 16] = b;
      cmd(OP_WRITE, b, 8'h00, 1'b0, 1'b1);
    end
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    k = 0;
    while (busy_out !== 1'b1 && k < 200) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    chk_bit("busy", 1'b1, busy_out);
    cmd(OP_START, ADDR_W, 8'h00, 1'b1, 1'b1);
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    $display("test page write done");
    poll_ack();
    b = 8'($random(seed));
    mem_exp[255] = b;
    cmd(OP_WRITE, 8'hFF, 8'h00, 1'b0, 1'b1);
    cmd(OP_WRITE, b, 8'h00, 1'b0, 1'b1);
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    $display("test byte write done");
    // random read at the top word, then across the wrap
    poll_ack();
    cmd(OP_WRITE, 8'hFF, 8'h00, 1'b0, 1'b1);
    cmd(OP_START, ADDR_R, 8'h00, 1'b0, 1'b1);
    cmd(OP_READ_ACK, 8'h00, mem_exp[255], 1'b0, 1'b1);
    for (i = 0; i < 14; i++) begin
      cmd(OP_READ_ACK, 8'h00, mem_exp[i], 1'b0, 1'b1);
    end
    cmd(OP_READ_LAST, 8'h00, mem_exp[14], 1'b0, 1'b1);
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    // current read continues after the last word read
    cmd(OP_START, ADDR_R, 8'h00, 1'b0, 1'b1);
    cmd(OP_READ_LAST, 8'h00, mem_exp[15], 1'b0, 1'b1);
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    $display("test reads done");
    // Other address ignored, and unknown op codes refused
    cmd(OP_START, ADDR_W ^ 8'h02, 8'h00, 1'b1, 1'b1);
    cmd(OP_STOP, 8'h00, 8'h00, 1'b0, 1'b1);
    for (i = 5; i < 8; i++) begin
      cmd(op_t'(i[2:0]), 8'h00, 8'h00, 1'b1, 1'b1);
    end
    $display("test refusals done");
    repeat (5) @(posedge core_clk_in);
    end_sim();
  end
endmodule : i2c_eeprom_memory_access_tb_top

`default_nettype wire

// ### line_filter.sv
// Purpose: two-flop synchroniser followed by a spike filter
// Assumes: line idles high
// Notes: output moves only after the input is stable STABLE cycles
`default_nettype none

module line_filter
  import eeprom_link_pkg::*;
#(
  parameter int STABLE = SPIKE_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Line
  input wire logic line_in,
  output logic line_out
);
  localparam int CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [CW-1:0] cnt;
  } flt_t;

  flt_t q;
  flt_t d;

  always_comb begin
    d = q;
    d.s1 = line_in;
    d.s2 = q.s1;
    if (q.s2 == q.lvl) begin
      d.cnt = '0;
    end else if (q.cnt == CW'(STABLE - 1)) begin
      d.lvl = q.s2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.s1 <= LINE_RELEASE;
      q.s2 <= LINE_RELEASE;
      q.lvl <= LINE_RELEASE;
    end else begin
      q <= d;
    end
  end

  assign line_out = q.lvl;
endmodule : line_filter

`default_nettype wire
